// ### bench/irq_host_model.sv
// host side of the two interrupt wires: pull-up, optional host drive
`timescale 1ns/100ps
module irq_host_model (
    input wire logic [1:0] dev_out,
    input wire logic [1:0] dev_oe,
    input wire logic [1:0] host_drv_en,
    input wire logic [1:0] host_val,
    output logic [1:0] wire_lvl
);
    // a released wire floats to the pull-up level, so open drain reads high when idle
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (dev_oe[i]) begin
                wire_lvl[i] = dev_out[i];
            end else if (host_drv_en[i]) begin
                wire_lvl[i] = host_val[i];
            end else begin
                wire_lvl[i] = 1'b1;
            end
        end
    end
endmodule // irq_host_model

// ### bench/tb_top.sv
// self-checking bench for the interrupt pin configuration block
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata;
    logic [1:0] evt_req = 2'h0;
    logic [1:0] pin_out, pin_oe, wire_lvl;
    logic [1:0] host_drv_en = 2'h0;
    logic [1:0] host_val = 2'h0;
    int n_errors = 0;
    int check_count = 0;

    always #25 core_clk = ~core_clk;

    interrupt_pin_config interrupt_pin_config_inst (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evt_req(evt_req),
        .first_interrupt_pin_in(wire_lvl[0]), .first_interrupt_pin_out(pin_out[0]),
        .first_interrupt_pin_oe(pin_oe[0]), .second_interrupt_pin_in(wire_lvl[1]),
        .second_interrupt_pin_out(pin_out[1]), .second_interrupt_pin_oe(pin_oe[1]), .irq(irq));
    irq_host_model irq_host_model_inst (.dev_out(pin_out), .dev_oe(pin_oe), .host_drv_en(host_drv_en),
        .host_val(host_val), .wire_lvl(wire_lvl));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hready is read as it stood before each rising edge; returns right after the edge that saw it high
    task automatic wait_ready();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) check(32'h1, 32'h0, "bus hang");
    endtask

    // request stands until hready is seen high; read data is taken at the edge ending the data phase
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {2'b00, idx, 2'b00};
        htrans <= irq_pin_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, irq_pin_pkg::HRESP_OKAY}, "response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        bus(idx, 1'b1, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] v;
        bus(idx, 1'b0, 32'h0000_0000, v);
        check(v, exp, msg);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // reset values, writable bits, unmapped place
    task automatic test_regs();
        rd_chk(irq_pin_pkg::IDX_PIN1_CFG, 32'h0000_0000, "pin1 cfg reset");
        rd_chk(irq_pin_pkg::IDX_PIN2_CFG, 32'h0000_0000, "pin2 cfg reset");
        rd_chk(irq_pin_pkg::IDX_HOLD_MODE, 32'h0000_0000, "hold reset");
        wr(irq_pin_pkg::IDX_HOLD_MODE, 32'hFFFF_FFFF);
        rd_chk(irq_pin_pkg::IDX_HOLD_MODE, 32'h0000_0001, "hold bits");
        wr(8'h70, 32'hFFFF_FFFF);
        rd_chk(8'h70, 32'h0000_0000, "unmapped");
        wr(irq_pin_pkg::IDX_HOLD_MODE, 32'h0000_0000);
    endtask

    // polarity and drive kind over every combination, then drive enable off once
    task automatic test_drive(input int p);
        logic [7:0] idx;
        logic lv;
        idx = (p == 0) ? irq_pin_pkg::IDX_PIN1_CFG : irq_pin_pkg::IDX_PIN2_CFG;
        for (int k = 0; k < 4; k++) begin
            wr(idx, {28'h0, 1'b1, k[1], k[0], 1'b0});
            for (int e = 0; e < 2; e++) begin
                @(posedge core_clk);
                evt_req[p] <= e[0];
                settle(3);
                lv = k[0] ? e[0] : ~e[0];
                check({31'h0, wire_lvl[p]}, {31'h0, lv}, "wire level");
                check({31'h0, pin_oe[p]}, {31'h0, k[1] ? ~lv : 1'b1}, "drive enable");
                if (k[1] == 1'b0) check({31'h0, pin_out[p]}, {31'h0, lv}, "push-pull out");
            end
        end
        wr(idx, 32'h0000_0002);
        settle(3);
        check({31'h0, pin_oe[p]}, 32'h0000_0000, "output disabled");
        @(posedge core_clk);
        evt_req[p] <= 1'b0;
        wr(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_000F);
    endtask

    // input sensing: disabled, level, edge; status and irq
    task automatic test_sense(input int p);
        logic [7:0] idx;
        logic [3:0] bitp;
        idx = (p == 0) ? irq_pin_pkg::IDX_PIN1_CFG : irq_pin_pkg::IDX_PIN2_CFG;
        bitp = 4'h1 << p;
        @(posedge core_clk);
        host_drv_en[p] <= 1'b1;
        host_val[p] <= 1'b1;
        wr(irq_pin_pkg::IDX_IRQ_MASK, {28'h0, bitp});
        for (int m = 0; m < 3; m++) begin
            wr(idx, (m == 0) ? 32'h0000_0002 : {27'h0, 1'b1, 3'h1, m[1]});
            settle(6);
            wr(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_000F);
            settle(6);
            rd_chk(irq_pin_pkg::IDX_IRQ_STATUS, (m == 1) ? {28'h0, bitp} : 32'h0, "sense status");
            check({31'h0, irq}, (m == 1) ? 32'h1 : 32'h0, "irq level");
        end
        wr(irq_pin_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        @(posedge core_clk);
        host_val[p] <= 1'b0;
        settle(6);
        // leaving the active level is not an edge
        rd_chk(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_0000, "falling ignored");
        @(posedge core_clk);
        host_val[p] <= 1'b1;
        settle(6);
        rd_chk(irq_pin_pkg::IDX_IRQ_STATUS, {28'h0, bitp}, "edge seen");
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(idx, 32'h0000_0000);
        host_drv_en[p] <= 1'b0;
        wr(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_000F);
    endtask

    // latched holds until status write-one; non-latched follows the pulse
    task automatic test_latch();
        wr(irq_pin_pkg::IDX_PIN1_CFG, 32'h0000_000A);
        for (int h = 1; h >= 0; h--) begin
            wr(irq_pin_pkg::IDX_HOLD_MODE, h);
            @(posedge core_clk);
            evt_req[0] <= 1'b1;
            @(posedge core_clk);
            evt_req[0] <= 1'b0;
            settle(4);
            check({31'h0, pin_out[0]}, h, "after pulse");
            rd_chk(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_0004, "event status");
            wr(irq_pin_pkg::IDX_IRQ_STATUS, 32'h0000_0004);
            settle(3);
            check({31'h0, pin_out[0]}, 32'h0, "after ack");
        end
    endtask

    initial begin
        #250000;
        n_errors++;
        results();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        test_regs();
        test_drive(0);
        test_drive(1);
        test_sense(0);
        test_sense(1);
        test_latch();
        results();
    end
endmodule // tb_top

// ### core/interrupt_pin_config.sv
// interrupt pin configuration block with ahb-lite register slave
`timescale 1ns/100ps
module interrupt_pin_config #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [1:0] evt_req,
    input wire logic first_interrupt_pin_in,
    output logic first_interrupt_pin_out,
    output logic first_interrupt_pin_oe,
    input wire logic second_interrupt_pin_in,
    output logic second_interrupt_pin_out,
    output logic second_interrupt_pin_oe,
    output logic irq
);
    localparam int ST_W = irq_pin_pkg::ST_W;
    localparam int CFG_W = irq_pin_pkg::CFG_W;

    // reset release
    logic rst_meta_ff, rst_sync_ff;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // address decode, word aligned; anything else selects nothing
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] a;
        a = addr;
        reg_sel = irq_pin_pkg::SEL_NONE;
        if (a[1:0] == 2'h0 && a[ADDR_W-1:10] == '0) begin
            case (a[9:2])
                irq_pin_pkg::IDX_PIN1_CFG: reg_sel = irq_pin_pkg::SEL_PIN1;
                irq_pin_pkg::IDX_PIN2_CFG: reg_sel = irq_pin_pkg::SEL_PIN2;
                irq_pin_pkg::IDX_HOLD_MODE: reg_sel = irq_pin_pkg::SEL_HOLD;
                irq_pin_pkg::IDX_IRQ_STATUS: reg_sel = irq_pin_pkg::SEL_STAT;
                irq_pin_pkg::IDX_IRQ_MASK: reg_sel = irq_pin_pkg::SEL_MASK;
                default: reg_sel = irq_pin_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // bus and register state
    logic wr_pend_ff, nxt_wr_pend;
    logic [2:0] wr_sel_ff, nxt_wr_sel;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, resp_ff;
    logic [CFG_W-1:0] cfg1_ff, nxt_cfg1;
    logic [CFG_W-1:0] cfg2_ff, nxt_cfg2;
    logic hold_ff, nxt_hold;
    logic [ST_W-1:0] status_ff, nxt_status;
    logic [ST_W-1:0] mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    logic [ST_W-1:0] clr, set;
    logic [2:0] sel;
    logic addr_phase;
    logic [1:0] active, sense_evt, ack, pin_in, pin_out, pin_oe;

    always_comb begin
        addr_phase = hready & hsel & (htrans == irq_pin_pkg::HTRANS_NONSEQ);
        sel = reg_sel(haddr);
        nxt_wr_pend = addr_phase & hwrite;
        nxt_wr_sel = addr_phase ? sel : irq_pin_pkg::SEL_NONE;
        // read data is fetched in the address phase so hrdata comes from a flop
        nxt_rdata = 32'h0000_0000;
        if (addr_phase && !hwrite) begin
            case (sel)
                irq_pin_pkg::SEL_PIN1: nxt_rdata[CFG_W-1:0] = cfg1_ff;
                irq_pin_pkg::SEL_PIN2: nxt_rdata[CFG_W-1:0] = cfg2_ff;
                irq_pin_pkg::SEL_HOLD: nxt_rdata[irq_pin_pkg::HOLD_BIT] = hold_ff;
                irq_pin_pkg::SEL_STAT: nxt_rdata[ST_W-1:0] = status_ff;
                irq_pin_pkg::SEL_MASK: nxt_rdata[ST_W-1:0] = mask_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // data phase write effects
    always_comb begin
        nxt_cfg1 = cfg1_ff;
        nxt_cfg2 = cfg2_ff;
        nxt_hold = hold_ff;
        nxt_mask = mask_ff;
        clr = '0;
        if (wr_pend_ff) begin
            case (wr_sel_ff)
                irq_pin_pkg::SEL_PIN1: nxt_cfg1 = hwdata[CFG_W-1:0];
                irq_pin_pkg::SEL_PIN2: nxt_cfg2 = hwdata[CFG_W-1:0];
                irq_pin_pkg::SEL_HOLD: nxt_hold = hwdata[irq_pin_pkg::HOLD_BIT];
                irq_pin_pkg::SEL_STAT: clr = hwdata[ST_W-1:0];
                irq_pin_pkg::SEL_MASK: nxt_mask = hwdata[ST_W-1:0];
                default: clr = '0;
            endcase
        end
        // writing one to an output status bit also acknowledges the held pin
        ack[0] = clr[irq_pin_pkg::ST_OUT1];
        ack[1] = clr[irq_pin_pkg::ST_OUT2];
        set = '0;
        set[irq_pin_pkg::ST_SENSE1] = sense_evt[0];
        set[irq_pin_pkg::ST_SENSE2] = sense_evt[1];
        set[irq_pin_pkg::ST_OUT1] = evt_req[0];
        set[irq_pin_pkg::ST_OUT2] = evt_req[1];
        // an event in the clearing cycle survives
        nxt_status = (status_ff & ~clr) | set;
        nxt_irq = |(status_ff & mask_ff);
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            wr_pend_ff <= 1'b0;
            wr_sel_ff <= irq_pin_pkg::SEL_NONE;
            rdata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
            resp_ff <= irq_pin_pkg::HRESP_OKAY;
            cfg1_ff <= irq_pin_pkg::CFG_RST;
            cfg2_ff <= irq_pin_pkg::CFG_RST;
            hold_ff <= irq_pin_pkg::HOLD_RST;
            status_ff <= irq_pin_pkg::STAT_RST;
            mask_ff <= irq_pin_pkg::MASK_RST;
            irq_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_sel_ff <= nxt_wr_sel;
            rdata_ff <= nxt_rdata;
            // zero wait states: ready rises one edge after reset release
            ready_ff <= 1'b1;
            resp_ff <= irq_pin_pkg::HRESP_OKAY;
            cfg1_ff <= nxt_cfg1;
            cfg2_ff <= nxt_cfg2;
            hold_ff <= nxt_hold;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
        end
    end

    assign pin_in[0] = first_interrupt_pin_in;
    assign pin_in[1] = second_interrupt_pin_in;

    // one channel per pin, both sharing the hold mode bit
    for (genvar i = 0; i < 2; i++) begin : g_pin
        irq_pin_channel u_chan (
            .core_clk(core_clk),
            .rst_n(rst_sync_ff),
            .cfg(i == 0 ? cfg1_ff : cfg2_ff),
            .hold_mode(hold_ff),
            .evt_req(evt_req[i]),
            .ack(ack[i]),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .active(active[i]),
            .sense_evt(sense_evt[i])
        );
    end

    assign first_interrupt_pin_out = pin_out[0];
    assign first_interrupt_pin_oe = pin_oe[0];
    assign second_interrupt_pin_out = pin_out[1];
    assign second_interrupt_pin_oe = pin_oe[1];
    assign hreadyout = ready_ff;
    assign hrdata = rdata_ff;
    assign hresp = resp_ff;
    assign irq = irq_ff;

    edge_pulse1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (cfg1_ff[irq_pin_pkg::CFG_EDGE] && $stable(cfg1_ff) && sense_evt[0]) |=> !sense_evt[0])
        else $error("edge mode sensed first pin twice in a row");

    level_hold1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (cfg1_ff[irq_pin_pkg::CFG_IN_EN] && !cfg1_ff[irq_pin_pkg::CFG_EDGE] && sense_evt[0])
        |-> ##1 status_ff[irq_pin_pkg::ST_SENSE1])
        else $error("level sense on first pin did not set status");

    polarity1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        ($past(cfg1_ff[irq_pin_pkg::CFG_OUT_EN]) && !$past(cfg1_ff[irq_pin_pkg::CFG_OD]))
        |-> first_interrupt_pin_out == ($past(active[0]) ~^ $past(cfg1_ff[irq_pin_pkg::CFG_LVL])))
        else $error("first pin level does not match polarity");

    open_drain1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        $past(cfg1_ff[irq_pin_pkg::CFG_OD]) |-> !first_interrupt_pin_out &&
        (first_interrupt_pin_oe == ($past(cfg1_ff[irq_pin_pkg::CFG_OUT_EN])
        && ($past(active[0]) != $past(cfg1_ff[irq_pin_pkg::CFG_LVL])))))
        else $error("first pin open drain drive wrong");

    drive_off1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        !cfg1_ff[irq_pin_pkg::CFG_OUT_EN] [*2] |-> !first_interrupt_pin_oe)
        else $error("first pin driven while disabled");

    drive_on1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        ($past(cfg1_ff[irq_pin_pkg::CFG_OUT_EN]) && !$past(cfg1_ff[irq_pin_pkg::CFG_OD]))
        |-> first_interrupt_pin_oe)
        else $error("first pin not driven while enabled");

    sense_off1_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        !cfg1_ff[irq_pin_pkg::CFG_IN_EN] |-> !sense_evt[0])
        else $error("first pin sensed while input disabled");

    edge_pulse2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (cfg2_ff[irq_pin_pkg::CFG_EDGE] && $stable(cfg2_ff) && sense_evt[1]) |=> !sense_evt[1])
        else $error("edge mode sensed second pin twice in a row");

    level_hold2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (cfg2_ff[irq_pin_pkg::CFG_IN_EN] && !cfg2_ff[irq_pin_pkg::CFG_EDGE] && sense_evt[1])
        |-> ##1 status_ff[irq_pin_pkg::ST_SENSE2])
        else $error("level sense on second pin did not set status");

    polarity2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        ($past(cfg2_ff[irq_pin_pkg::CFG_OUT_EN]) && !$past(cfg2_ff[irq_pin_pkg::CFG_OD]))
        |-> second_interrupt_pin_out == ($past(active[1]) ~^ $past(cfg2_ff[irq_pin_pkg::CFG_LVL])))
        else $error("second pin level does not match polarity");

    open_drain2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        $past(cfg2_ff[irq_pin_pkg::CFG_OD]) |-> !second_interrupt_pin_out &&
        (second_interrupt_pin_oe == ($past(cfg2_ff[irq_pin_pkg::CFG_OUT_EN])
        && ($past(active[1]) != $past(cfg2_ff[irq_pin_pkg::CFG_LVL])))))
        else $error("second pin open drain drive wrong");

    drive_off2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        $past(cfg2_ff[irq_pin_pkg::CFG_OUT_EN]) == 1'b0 |-> !second_interrupt_pin_oe)
        else $error("second pin driven while disabled");

    drive_on2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        ($past(cfg2_ff[irq_pin_pkg::CFG_OUT_EN]) && !$past(cfg2_ff[irq_pin_pkg::CFG_OD]))
        |-> second_interrupt_pin_oe)
        else $error("second pin not driven while enabled");

    sense_off2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (!cfg2_ff[irq_pin_pkg::CFG_IN_EN] && !status_ff[irq_pin_pkg::ST_SENSE2])
        |=> !status_ff[irq_pin_pkg::ST_SENSE2])
        else $error("second pin status set while input disabled");

    live_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (!$past(hold_ff) && $past(cfg1_ff[irq_pin_pkg::CFG_LVL]) && !$past(cfg1_ff[irq_pin_pkg::CFG_OD]))
        |-> first_interrupt_pin_out == $past(evt_req[0]))
        else $error("non-latched pin does not follow event");

    latch_keep_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (hold_ff && active[0] && !ack[0]) ##1 hold_ff |-> active[0])
        else $error("latched first pin dropped without acknowledge");

    latch_keep2_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        (hold_ff && active[1] && !ack[1]) ##1 hold_ff |-> active[1])
        else $error("latched second pin dropped without acknowledge");

    bus_okay_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        hresp == irq_pin_pkg::HRESP_OKAY)
        else $error("bus response not okay");

    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
        ##1 irq == |($past(status_ff) & $past(mask_ff)))
        else $error("interrupt output does not match masked status");
endmodule // interrupt_pin_config

// ### core/irq_pin_channel.sv
// one interrupt pin: output drive, hold latch and input sensing
`timescale 1ns/100ps
module irq_pin_channel (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [irq_pin_pkg::CFG_W-1:0] cfg,
    input wire logic hold_mode,
    input wire logic evt_req,
    input wire logic ack,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic active,
    output logic sense_evt
);
    logic held_ff, nxt_held;
    logic out_ff, nxt_out;
    logic oe_ff, nxt_oe;
    logic sync1_ff, sync2_ff, prev_ff;
    logic pin_level, in_now, in_prev;

    always_comb begin
        // set wins over an acknowledge in the same cycle
        nxt_held = evt_req | (held_ff & ~ack);
        active = hold_mode ? held_ff : evt_req;
        pin_level = cfg[irq_pin_pkg::CFG_LVL] ? active : ~active;
        // open drain only ever pulls low; the high level comes from the pull-up
        if (cfg[irq_pin_pkg::CFG_OD]) begin
            nxt_out = 1'b0;
            nxt_oe = cfg[irq_pin_pkg::CFG_OUT_EN] & ~pin_level;
        end else begin
            nxt_out = pin_level;
            nxt_oe = cfg[irq_pin_pkg::CFG_OUT_EN];
        end
        // the active level of a sensed input follows the polarity bit
        in_now = cfg[irq_pin_pkg::CFG_LVL] ? sync2_ff : ~sync2_ff;
        in_prev = cfg[irq_pin_pkg::CFG_LVL] ? prev_ff : ~prev_ff;
        if (!cfg[irq_pin_pkg::CFG_IN_EN]) begin
            sense_evt = 1'b0;
        end else if (cfg[irq_pin_pkg::CFG_EDGE]) begin
            sense_evt = in_now & ~in_prev;
        end else begin
            sense_evt = in_now;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_ff <= 1'b0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            held_ff <= nxt_held;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
endmodule // irq_pin_channel

// ### core/irq_pin_pkg.sv
// constants for the interrupt pin configuration block
package irq_pin_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PIN1_CFG = 8'h53;
    localparam logic [7:0] IDX_PIN2_CFG = 8'h54;
    localparam logic [7:0] IDX_HOLD_MODE = 8'h55;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;

    // decoded register selects
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_PIN1 = 3'h1;
    localparam logic [2:0] SEL_PIN2 = 3'h2;
    localparam logic [2:0] SEL_HOLD = 3'h3;
    localparam logic [2:0] SEL_STAT = 3'h4;
    localparam logic [2:0] SEL_MASK = 3'h5;

    // pin configuration field positions
    localparam int CFG_W = 5;
    localparam int CFG_EDGE = 0;
    localparam int CFG_LVL = 1;
    localparam int CFG_OD = 2;
    localparam int CFG_OUT_EN = 3;
    localparam int CFG_IN_EN = 4;
    localparam int HOLD_BIT = 0;

    // status and mask layout
    localparam int ST_W = 4;
    localparam int ST_SENSE1 = 0;
    localparam int ST_SENSE2 = 1;
    localparam int ST_OUT1 = 2;
    localparam int ST_OUT2 = 3;

    // reset values
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
    localparam logic HOLD_RST = 1'b0;
    localparam logic [ST_W-1:0] STAT_RST = 4'h0;
    localparam logic [ST_W-1:0] MASK_RST = 4'h0;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage
